// [common/pag_pkg.sv]
// Package for the port A GPIO block with pin sharing: offsets, fields, reset values.
// Contract
// [RQ1] Eight software read/write port A latch bits, direction set per bit.
// [RQ2] Reset leaves the port A output latch contents unchanged.
// [RQ3] Direction 1 drives the pin as output; 0 leaves it high-impedance input.
// [RQ4] Reset clears all eight port A direction bits, so pins start as inputs.
// [RQ5] Data read returns the latch for bits whose direction is 1.
// [RQ6] Data read returns the synchronised pin level for bits whose direction is 0.
// [RQ7] Data writes always update the latch; input pins still read the pin.
// [RQ8] Keypad enable on pins 0 to 3 takes the pin from port control.
// [RQ9] Converter channel select naming pins 4 to 7 takes that pin from port control.
// [RQ10] Pins not chosen as converter channels behave as plain digital I/O.
// [RQ11] Software writes the latch before turning a direction bit from 0 to 1.
// [RQ12] Port B pins 0 and 1 are shared as converter inputs by channel select.
// [RQ13] Port B pins 2 to 5 go to timer channels when edge/level select nonzero.
// [RQ14] Port B pin 2 is the periodic interrupt external clock when select is 01.
// [RQ15] Port B pins 6 and 7 become LCD frontplanes when the LCD enable is set.
// [RQ16] Port C 0-5, D and E become frontplanes by per-port enables with LCD enable.
// [RQ17] An alternate function owning a pin stops port drive; latch and direction kept.
package pag_pkg;
   // Register word offsets (byte addresses on the Wishbone bus)
   localparam logic [7:0] PAG_OFS_DATA = 8'h00;
   localparam logic [7:0] PAG_OFS_DIR = 8'h10;
   localparam logic [7:0] PAG_OFS_OWNER = 8'h14;
   localparam logic [7:0] PAG_OFS_SHARE = 8'h18;
   // Port width and split between keypad and converter pins
   localparam int PAG_WIDTH = 8;
   localparam int PAG_KEYPAD_PINS = 4;
   // Converter channel codes for port A pins 4..7 and port B pins 0..1
   localparam logic [4:0] PAG_ADC_CH_PA_FIRST = 5'h00;
   localparam logic [4:0] PAG_ADC_CH_PB_FIRST = 5'h04;
   localparam int PAG_ADC_PA_COUNT = 4;
   localparam int PAG_ADC_PB_COUNT = 2;
   // Periodic interrupt clock select code for the external pin
   localparam logic [1:0] PAG_PPI_EXT_SEL = 2'h1;
   // Reset value and unmapped-offset read value
   localparam logic [7:0] PAG_DIR_RESET = 8'h00;
   localparam logic [31:0] PAG_UNMAPPED_READ = 32'h0000_0000;
endpackage

// [verilog/pag_sync.sv]
// Two-stage synchroniser bank for the pin inputs.
`timescale 1ns/10ps
module pag_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   // First stage feeds only the second; no reset, so pin levels reach q two clocks later, in reset too
   always_ff @(posedge clk) begin
      meta <= d;
      q <= meta;
   end
endmodule

// [verilog/pag_port_a.sv]
// Port A GPIO with alternate-function ownership and port B-E sharing map.
`timescale 1ns/10ps
module pag_port_a
   import pag_pkg::*;
#(
   parameter int WIDTH = pag_pkg::PAG_WIDTH
) (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic [WIDTH-1:0] PA_PIN_I,
   output logic [WIDTH-1:0] PA_PIN_O,
   output logic [WIDTH-1:0] PA_PIN_OE_N,
   input wire logic [3:0] KEYPAD_IRQ_ENABLE,
   input wire logic [4:0] CONVERTER_CHANNEL_SELECT,
   input wire logic CONVERTER_ACTIVE,
   input wire logic [1:0] FIRST_TIMER_CH0_ELS,
   input wire logic [1:0] FIRST_TIMER_CH1_ELS,
   input wire logic [1:0] SECOND_TIMER_CH0_ELS,
   input wire logic [1:0] SECOND_TIMER_CH1_ELS,
   input wire logic [1:0] PERIODIC_IRQ_CLOCK_SELECT,
   input wire logic LCD_ENABLE_BIT,
   input wire logic PORT_C_LOW_LCD_ENABLE,
   input wire logic PORT_C_HIGH_LCD_ENABLE,
   input wire logic PORT_D_LCD_ENABLE,
   input wire logic PORT_E_LCD_ENABLE,
   output logic [WIDTH-1:0] PA_ALT_OWNED,
   output logic [WIDTH-1:0] PB_ALT_OWNED,
   output logic [WIDTH-1:0] PC_ALT_OWNED,
   output logic PD_ALT_OWNED,
   output logic PE_ALT_OWNED,
   output logic PB2_PERIODIC_CLK_SEL
);
   import pag_pkg::*;

   logic [WIDTH-1:0] port_a_output_latch;
   logic [WIDTH-1:0] port_a_direction;
   logic [WIDTH-1:0] pin_sync;
   logic [WIDTH-1:0] owned;
   logic [WIDTH-1:0] next_pb_owned;
   logic [WIDTH-1:0] next_pc_owned;
   logic [WIDTH-1:0] read_data;
   logic [31:0] next_dat;
   logic bus_req;
   logic wr_strobe;

   // True when the converter selects channel code base+idx
   function automatic logic adc_hit(input logic [4:0] sel, input logic [4:0] base,
                                    input int idx);
      adc_hit = (sel == (base + 5'(idx)));
   endfunction

   // Timer channel owns its pin when the edge/level pair is nonzero
   function automatic logic timer_owns(input logic [1:0] els);
      timer_owns = (els != 2'h0);
   endfunction

   // External pins pass two flip-flops before any logic reads them
   pag_sync #(.WIDTH(WIDTH)) u_pin_sync (
      .clk(MCLK),
      .d(PA_PIN_I),
      .q(pin_sync)
   );

   // One request per classic cycle; ack drops the cycle after it is given
   assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   assign wr_strobe = bus_req && WB_WE_I && WB_SEL_I[0];

   // Port A ownership: keypad on the low pins, converter on the high pins
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_own
         if (gi < PAG_KEYPAD_PINS) begin : g_kbd
            assign owned[gi] = KEYPAD_IRQ_ENABLE[gi]; // [RQ8]
         end else begin : g_adc
            // Unselected pins stay plain digital I/O
            assign owned[gi] = CONVERTER_ACTIVE &&
               adc_hit(CONVERTER_CHANNEL_SELECT, PAG_ADC_CH_PA_FIRST,
                       gi - PAG_KEYPAD_PINS); // [RQ9] [RQ10]
         end
      end
   endgenerate

   // Data latch: no reset term at all, so system reset leaves it intact
   always_ff @(posedge MCLK) begin
      if (wr_strobe && WB_ADR_I == PAG_OFS_DATA) begin
         port_a_output_latch <= WB_DAT_I[WIDTH-1:0]; // [RQ1] [RQ2] [RQ7]
      end
   end

   // Direction register clears on reset so every pin starts as input
   always_ff @(posedge MCLK) begin
      if (RST) begin
         port_a_direction <= PAG_DIR_RESET; // [RQ4]
      end else if (wr_strobe && WB_ADR_I == PAG_OFS_DIR) begin
         port_a_direction <= WB_DAT_I[WIDTH-1:0]; // [RQ1]
      end
   end

   // Pin drivers; an owned pin loses port drive but keeps its stored state.
   // Software is expected to load the latch before raising a direction bit,
   // otherwise the old latch value drives the pin until the latch is written.
   always_ff @(posedge MCLK) begin
      if (RST) begin
         PA_PIN_OE_N <= '1;
         PA_PIN_O <= '0;
      end else begin
         PA_PIN_OE_N <= ~(port_a_direction & ~owned); // [RQ3] [RQ17] [RQ11]
         PA_PIN_O <= port_a_output_latch;
      end
   end

   // Read mux per bit: latch for outputs, synchronised pin for inputs
   always_comb begin
      read_data = (port_a_direction & port_a_output_latch) |
                  (~port_a_direction & pin_sync); // [RQ5] [RQ6]
   end

   // Port B sharing map
   always_comb begin
      next_pb_owned = '0;
      for (int i = 0; i < PAG_ADC_PB_COUNT; i++) begin
         next_pb_owned[i] = CONVERTER_ACTIVE &&
            adc_hit(CONVERTER_CHANNEL_SELECT, PAG_ADC_CH_PB_FIRST, i); // [RQ12]
      end
      next_pb_owned[2] = timer_owns(FIRST_TIMER_CH0_ELS) ||
                         (PERIODIC_IRQ_CLOCK_SELECT == PAG_PPI_EXT_SEL); // [RQ13] [RQ14]
      next_pb_owned[3] = timer_owns(FIRST_TIMER_CH1_ELS); // [RQ13]
      next_pb_owned[4] = timer_owns(SECOND_TIMER_CH0_ELS); // [RQ13]
      next_pb_owned[5] = timer_owns(SECOND_TIMER_CH1_ELS); // [RQ13]
      next_pb_owned[6] = LCD_ENABLE_BIT; // [RQ15]
      next_pb_owned[7] = LCD_ENABLE_BIT; // [RQ15]
   end

   // Port C: pins 0-3 by the low enable, 4-5 by the high one, 6-7 plain I/O
   always_comb begin
      next_pc_owned = '0;
      next_pc_owned[3:0] = {4{LCD_ENABLE_BIT && PORT_C_LOW_LCD_ENABLE}}; // [RQ16]
      next_pc_owned[5:4] = {2{LCD_ENABLE_BIT && PORT_C_HIGH_LCD_ENABLE}}; // [RQ16]
   end

   // Sharing outputs registered so every output leaves a flip-flop
   always_ff @(posedge MCLK) begin
      if (RST) begin
         PA_ALT_OWNED <= '0;
         PB_ALT_OWNED <= '0;
         PC_ALT_OWNED <= '0;
         PD_ALT_OWNED <= 1'b0;
         PE_ALT_OWNED <= 1'b0;
         PB2_PERIODIC_CLK_SEL <= 1'b0;
      end else begin
         PA_ALT_OWNED <= owned; // [RQ17]
         PB_ALT_OWNED <= next_pb_owned;
         PC_ALT_OWNED <= next_pc_owned;
         PD_ALT_OWNED <= LCD_ENABLE_BIT && PORT_D_LCD_ENABLE; // [RQ16]
         PE_ALT_OWNED <= LCD_ENABLE_BIT && PORT_E_LCD_ENABLE; // [RQ16]
         PB2_PERIODIC_CLK_SEL <= (PERIODIC_IRQ_CLOCK_SELECT == PAG_PPI_EXT_SEL); // [RQ14]
      end
   end

   // Read data selection; unmapped offsets read zero and still acknowledge
   always_comb begin
      next_dat = PAG_UNMAPPED_READ;
      case (WB_ADR_I)
         PAG_OFS_DATA: next_dat = {24'h0, read_data};
         PAG_OFS_DIR: next_dat = {24'h0, port_a_direction};
         PAG_OFS_OWNER: next_dat = {24'h0, owned};
         PAG_OFS_SHARE: next_dat = {24'h0, next_pb_owned};
         default: next_dat = PAG_UNMAPPED_READ;
      endcase
   end

   // Ack one cycle after the request, read data registered with it
   always_ff @(posedge MCLK) begin
      if (RST) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= '0;
      end else begin
         WB_ACK_O <= bus_req;
         WB_DAT_O <= bus_req ? next_dat : 32'h0;
      end
   end
endmodule

// [bench/pag_port_a_sva.sv]
// Assertion checker for the port A GPIO block and its sharing map.
`timescale 1ns/10ps
module pag_port_a_sva
   import pag_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_ACK_O,
   input wire logic [7:0] PA_PIN_OE_N,
   input wire logic [7:0] PA_ALT_OWNED,
   input wire logic [7:0] PB_ALT_OWNED,
   input wire logic PB2_PERIODIC_CLK_SEL,
   input wire logic [3:0] KEYPAD_IRQ_ENABLE,
   input wire logic [4:0] CONVERTER_CHANNEL_SELECT,
   input wire logic CONVERTER_ACTIVE,
   input wire logic [1:0] FIRST_TIMER_CH1_ELS,
   input wire logic [1:0] PERIODIC_IRQ_CLOCK_SELECT,
   input wire logic LCD_ENABLE_BIT
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   // Bus answer comes one cycle after the request and lasts one cycle
   property p_ack_lat; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack late");
   property p_ack_one; WB_ACK_O |=> !WB_ACK_O; endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack long");
   // Reset must release every pin, so it is not disabled by itself
   property p_rst_oe; disable iff (1'b0) RST |=> PA_PIN_OE_N == 8'hff; endproperty
   a_rst_oe: assert property (p_rst_oe) else $error("pins driven after reset");
   // Two cycles allow for ownership being registered one cycle behind the enable
   property p_kbi; KEYPAD_IRQ_ENABLE[0] [*2] |=> PA_PIN_OE_N[0] && PA_ALT_OWNED[0]; endproperty
   a_kbi: assert property (p_kbi) else $error("keypad pin driven");
   property p_adc; CONVERTER_ACTIVE && CONVERTER_CHANNEL_SELECT == 5'h03 |=> PA_ALT_OWNED[7];
   endproperty
   a_adc: assert property (p_adc) else $error("converter pin free");
   property p_tmr; FIRST_TIMER_CH1_ELS != 2'h0 |=> PB_ALT_OWNED[3]; endproperty
   a_tmr: assert property (p_tmr) else $error("timer pin free");
   property p_ppi; PERIODIC_IRQ_CLOCK_SELECT == PAG_PPI_EXT_SEL |=> PB2_PERIODIC_CLK_SEL;
   endproperty
   a_ppi: assert property (p_ppi) else $error("ext clock off");
   property p_lcd; 1'b1 |=> PB_ALT_OWNED[7:6] == {2{$past(LCD_ENABLE_BIT)}}; endproperty
   a_lcd: assert property (p_lcd) else $error("frontplane map");
endmodule
bind pag_port_a pag_port_a_sva pag_port_a_sva_i (.*);

// [bench/pag_pin_model.sv]
// Pad model for port A: port drive against an outside source.
`timescale 1ns/10ps
module pag_pin_model (
   input wire logic [7:0] pin_o,
   input wire logic [7:0] oe_n,
   input wire logic [7:0] ext,
   output logic [7:0] pin_i
);
   // Outside source shows wherever the port buffer is off
   assign pin_i = (~oe_n & pin_o) | (oe_n & ext);
endmodule

// [bench/pag_port_a_tb.sv]
// Self-checking bench for the port A GPIO block.
`timescale 1ns/10ps
module pag_port_a_tb;
   import pag_pkg::*;
   logic MCLK = 0, RST = 1, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0, CONVERTER_ACTIVE = 0;
   logic LCD_ENABLE_BIT = 0, PORT_C_LOW_LCD_ENABLE = 0, PORT_C_HIGH_LCD_ENABLE = 0;
   logic PORT_D_LCD_ENABLE = 0, PORT_E_LCD_ENABLE = 0, WB_ACK_O, PD_ALT_OWNED, PE_ALT_OWNED;
   logic PB2_PERIODIC_CLK_SEL;
   logic [7:0] WB_ADR_I = 0, ext = 8'h3c, PA_PIN_I, PA_PIN_O, PA_PIN_OE_N;
   logic [7:0] PA_ALT_OWNED, PB_ALT_OWNED, PC_ALT_OWNED;
   logic [3:0] WB_SEL_I = 4'h1, KEYPAD_IRQ_ENABLE = 0;
   logic [31:0] WB_DAT_I = 0, WB_DAT_O, rd;
   logic [4:0] CONVERTER_CHANNEL_SELECT = 5'h1f;
   logic [1:0] FIRST_TIMER_CH0_ELS = 0, FIRST_TIMER_CH1_ELS = 0, PERIODIC_IRQ_CLOCK_SELECT = 0;
   logic [1:0] SECOND_TIMER_CH0_ELS = 0, SECOND_TIMER_CH1_ELS = 0;
   int error_cnt = 0, checks_done = 0;
   pag_port_a pag_port_a_i (.*);
   pag_pin_model pag_pin_model_i (.pin_o(PA_PIN_O), .oe_n(PA_PIN_OE_N), .ext(ext), .pin_i(PA_PIN_I));
   // 50 MHz bus clock
   always #10 MCLK = ~MCLK;
   task automatic finish_test();
      $display("Checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One classic cycle; a missing answer ends the run
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge MCLK);
      WB_CYC_I <= 1;
      WB_STB_I <= 1;
      WB_WE_I <= w;
      WB_ADR_I <= a;
      WB_DAT_I <= {24'h0, d};
      do begin
         @(posedge MCLK);
         n++;
      end while (WB_ACK_O !== 1'b1 && n < 16);
      rd = WB_DAT_O;
      WB_CYC_I <= 0;
      WB_STB_I <= 0;
      if (n >= 16) begin
         error_cnt++;
         finish_test();
      end
   endtask
   initial begin
      repeat (20) @(posedge MCLK);
      RST <= 0;
      wb(0, PAG_OFS_DIR, 0);
      chk("dir", 0, rd);
      chk("oe", 8'hff, PA_PIN_OE_N);
      wb(1, PAG_OFS_DATA, 8'ha5);
      repeat (4) @(posedge MCLK);
      wb(0, PAG_OFS_DATA, 0);
      chk("in read", 8'h3c, rd);
      wb(1, PAG_OFS_DIR, 8'hf0);
      repeat (4) @(posedge MCLK);
      wb(0, PAG_OFS_DATA, 0);
      chk("mix read", 8'hac, rd);
      chk("mix oe", 8'h0f, PA_PIN_OE_N);
      // Owned pins show the outside level while the latch still reads back
      wb(1, PAG_OFS_DIR, 8'hff);
      KEYPAD_IRQ_ENABLE <= 4'h1;
      CONVERTER_ACTIVE <= 1;
      CONVERTER_CHANNEL_SELECT <= 5'h03;
      repeat (4) @(posedge MCLK);
      chk("own oe", 8'h81, PA_PIN_OE_N);
      chk("own alt", 8'h81, PA_ALT_OWNED);
      chk("pin out", 8'ha5, PA_PIN_O);
      wb(0, PAG_OFS_DATA, 0);
      chk("own read", 8'ha5, rd);
      KEYPAD_IRQ_ENABLE <= 0;
      CONVERTER_ACTIVE <= 0;
      repeat (4) @(posedge MCLK);
      chk("free oe", 0, PA_PIN_OE_N);
      wb(0, 8'h40, 0);
      chk("unmapped", PAG_UNMAPPED_READ, rd);
      wb(1, PAG_OFS_DATA, 8'h5a);
      RST <= 1;
      repeat (2) @(posedge MCLK);
      RST <= 0;
      wb(1, PAG_OFS_DIR, 8'hff);
      wb(0, PAG_OFS_DATA, 0);
      chk("latch kept", 8'h5a, rd);
      LCD_ENABLE_BIT <= 1;
      PORT_C_LOW_LCD_ENABLE <= 1;
      PORT_C_HIGH_LCD_ENABLE <= 1;
      PORT_D_LCD_ENABLE <= 1;
      FIRST_TIMER_CH1_ELS <= 2'h2;
      SECOND_TIMER_CH0_ELS <= 2'h3;
      SECOND_TIMER_CH1_ELS <= 2'h1;
      PERIODIC_IRQ_CLOCK_SELECT <= PAG_PPI_EXT_SEL;
      CONVERTER_ACTIVE <= 1;
      CONVERTER_CHANNEL_SELECT <= 5'h05;
      repeat (3) @(posedge MCLK);
      chk("b map", 8'hfe, PB_ALT_OWNED);
      chk("c map", 8'h3f, PC_ALT_OWNED);
      chk("d e map", 2'h2, {PD_ALT_OWNED, PE_ALT_OWNED});
      finish_test();
   end
endmodule
